// file: common/hwcms_pkg.sv
// Package of constants shared by the start-up and pin-strap control block
package hwcms_pkg;
	// Register bus geometry
	localparam int ADDR_W = 7;
	localparam int DATA_W = 9;
	// Register addresses
	localparam logic [6:0] ADDR_IDENT_ONE     = 7'h00;
	localparam logic [6:0] ADDR_IDENT_TWO     = 7'h01;
	localparam logic [6:0] ADDR_REVISION      = 7'h02;
	localparam logic [6:0] ADDR_ADC_CONTROL_ONE = 7'h1d;
	localparam logic [6:0] ADDR_PRI_PORT_THREE = 7'h0c;
	localparam logic [6:0] ADDR_PRI_PORT_FOUR  = 7'h0d;
	localparam logic [6:0] ADDR_SEC_PORT_TWO   = 7'h0e;
	// Identification values (arbitrary neutral values)
	localparam logic [8:0] IDENT_ONE_VAL      = 9'h05a;
	localparam logic [8:0] IDENT_TWO_VAL      = 9'h0a5;
	localparam logic [8:0] REVISION_VAL       = 9'h001;
	// Field positions
	localparam int MIDRAIL_BIT   = 8;
	localparam int SRC_HI        = 8;
	localparam int SRC_LO        = 7;
	localparam int SEC_EN_BIT    = 6;
	localparam int FMT_HI        = 1;
	localparam int FMT_LO        = 0;
	localparam int WL_HI         = 3;
	localparam int WL_LO         = 2;
	// Reset values
	localparam logic [8:0] ADC_CONTROL_ONE_RST = 9'h100;
	localparam logic [8:0] PRI_PORT_THREE_RST  = 9'h18a;
	localparam logic [8:0] PRI_PORT_FOUR_RST   = 9'h08a;
	localparam logic [8:0] SEC_PORT_TWO_RST    = 9'h00a;
	// Routing source codes
	localparam logic [1:0] DAC_FROM_SPDIF = 2'h0;
	localparam logic [1:0] DAC_FROM_PRI   = 2'h1;
	localparam logic [1:0] PTX_SRC_SPDIF = 2'h0;
	localparam logic [1:0] PTX_SRC_ADC   = 2'h1;
	// Primary port formats and word lengths
	localparam logic [1:0] FMT_RJ  = 2'h0;
	localparam logic [1:0] FMT_LJ  = 2'h1;
	localparam logic [1:0] FMT_I2S = 2'h2;
	localparam logic [1:0] WL_20   = 2'h1;
	localparam logic [1:0] WL_24   = 2'h2;
	// Channel status block length
	localparam logic [7:0] BLOCK_FRAMES = 8'hc0;
	// Start-up states
	typedef enum logic [1:0] {HWCMS_HOLD, HWCMS_LOAD, HWCMS_READY} hwcms_state_t;
endpackage

// file: dv/hw_control_mode_and_startup_tb.sv
// Self-checking testbench of the start-up and pin-strap control block
`timescale 1ns/1ps
module hw_control_mode_and_startup_tb;
	import hwcms_pkg::*;
	localparam int FL = 4; // Frame length used by the partner
	logic i_mclk = 1'b0, i_rst_n = 1'b0, i_internal_reset_n = 1'b0; // Clock and resets
	logic i_wr_en = 1'b0, i_rd_en = 1'b0, i_continuous_readback = 1'b0; // Bus strobes
	logic [6:0] i_addr = 7'h00; // Register address
	logic [8:0] i_wdata = 9'h000, d; // Write data and scratch word
	logic mode_pin = 1'b0, bus_sel_strap = 1'b0, run = 1'b0; // Straps and partner enable
	logic [5:0] straps = 6'h00; // Serial clock, chip select, route d,c,b,a (msb first)
	logic unlock, pcm_n, audio_n, cs_bit, sub_a, frame_start; // Partner flags
	logic [8:0] o_rdata; // Read data
	logic o_rvalid, o_ready, o_hw_mode, o_three_wire, o_sec_en, o_midrail; // Status
	logic [1:0] o_dac, o_ptx, o_stx, o_fmt, o_wl; // Decoded settings
	logic cbs_o, cbs_oe, dout_o, dout_oe, pin8, pin9, pin10; // Status pins
	wire bus_sel_w = cbs_oe ? cbs_o : bus_sel_strap; // Two-way pin level
	int err_count = 0, checked = 0, n, i; // Counters
	logic [5:0] r; // Strap pattern
	always #4 i_mclk = ~i_mclk;
	hwcms_partner #(.FRAME_LEN(FL)) i_partner (.i_mclk(i_mclk), .i_run(run),
		.o_unlock(unlock), .o_pcm_n(pcm_n), .o_audio_n(audio_n),
		.o_channel_status_bit(cs_bit), .o_subframe_a(sub_a), .o_frame_start(frame_start));
	hwcms_top i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
		.i_internal_reset_n(i_internal_reset_n), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_continuous_readback(i_continuous_readback),
		.i_control_mode_pin(mode_pin), .i_control_bus_select_pin(bus_sel_w),
		.i_route_pin_a(straps[0]), .i_route_pin_b(straps[1]), .i_route_pin_c(straps[2]),
		.i_route_pin_d(straps[3]), .i_chip_select_pin(straps[4]),
		.i_serial_clock_pin(straps[5]), .i_unlock(unlock), .i_pcm_n(pcm_n),
		.i_audio_n(audio_n), .i_channel_status_bit(cs_bit), .i_subframe_a(sub_a),
		.i_frame_start(frame_start), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
		.o_ready(o_ready), .o_hw_mode(o_hw_mode), .o_three_wire(o_three_wire),
		.o_dac_source_select(o_dac), .o_primary_tx_source_select(o_ptx),
		.o_spdif_tx_source_select(o_stx), .o_secondary_audio_port_en(o_sec_en),
		.o_primary_fmt(o_fmt), .o_primary_wl(o_wl), .o_midrail_impedance_select(o_midrail),
		.o_control_bus_select_pin_o(cbs_o), .o_control_bus_select_pin_oe(cbs_oe),
		.o_serial_data_out_pin_o(dout_o), .o_serial_data_out_pin_oe(dout_oe),
		.o_multifunction_pin_eight(pin8), .o_multifunction_pin_nine(pin9),
		.o_multifunction_pin_ten(pin10));
	// Expected word length and format from chip select and serial clock
	function automatic logic [3:0] fmt_exp(input logic [1:0] cs_sc);
		case (cs_sc)
			2'h0: return {WL_24, FMT_RJ};
			2'h1: return {WL_20, FMT_RJ};
			2'h2: return {WL_24, FMT_LJ};
			default: return {WL_24, FMT_I2S};
		endcase
	endfunction
	// Compare one result and count it
	task automatic check(input logic [8:0] got, input logic [8:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One-cycle write strobe
	task automatic reg_wr(input logic [6:0] a, input logic [8:0] wd);
		@(negedge i_mclk);
		{i_wr_en, i_addr, i_wdata} = {1'b1, a, wd};
		@(negedge i_mclk);
		i_wr_en = 1'b0;
	endtask
	// One-cycle read strobe, answer expected in the following cycle
	task automatic reg_rd(input logic [6:0] a, input logic [8:0] exp);
		@(negedge i_mclk);
		{i_rd_en, i_addr} = {1'b1, a};
		@(negedge i_mclk);
		i_rd_en = 1'b0;
		check(9'(o_rvalid), 9'h001);
		check(o_rdata, exp);
	endtask
	// Print the counts and the verdict, then stop
	task automatic give_verdict();
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Watchdog against a hung handshake
	initial begin
		#100us;
		err_count++;
		give_verdict();
	end
	// Main sequence
	initial begin
		void'($urandom(37));
		repeat (4) @(posedge i_mclk);
		@(negedge i_mclk) i_rst_n = 1'b1;
		reg_wr(ADDR_ADC_CONTROL_ONE, 9'h000);
		check(9'(o_ready), 9'h000);
		@(negedge i_mclk) i_internal_reset_n = 1'b1;
		for (n = 0; n < 50 && o_ready !== 1'b1; n++) @(negedge i_mclk);
		check(9'(o_ready), 9'h001);
		check(9'(o_midrail), 9'h001);
		reg_rd(ADDR_ADC_CONTROL_ONE, ADC_CONTROL_ONE_RST);
		reg_rd(ADDR_IDENT_ONE, IDENT_ONE_VAL);
		reg_rd(ADDR_IDENT_TWO, IDENT_TWO_VAL);
		reg_rd(ADDR_REVISION, REVISION_VAL);
		i_continuous_readback = 1'b1;
		reg_rd(ADDR_IDENT_ONE, 9'h000);
		i_continuous_readback = 1'b0;
		for (i = 0; i < 6; i++) begin
			d = 9'($urandom);
			d[MIDRAIL_BIT] = (i < 2) ? i[0] : d[MIDRAIL_BIT];
			reg_wr(ADDR_ADC_CONTROL_ONE, d);
			reg_rd(ADDR_ADC_CONTROL_ONE, d);
			check(9'(o_midrail), 9'(d[MIDRAIL_BIT]));
		end
		reg_wr(ADDR_ADC_CONTROL_ONE, 9'h000);
		for (i = 0; i < 2; i++) begin
			bus_sel_strap = i[0];
			repeat (8) @(negedge i_mclk);
			check(9'({o_hw_mode, cbs_oe, o_midrail}), 9'h000);
			check(9'(o_three_wire), 9'(i[0]));
		end
		mode_pin = 1'b1;
		repeat (8) @(negedge i_mclk);
		check(9'(o_hw_mode), 9'h001);
		reg_wr(ADDR_ADC_CONTROL_ONE, 9'h000);
		check(9'(o_midrail), 9'h001);
		for (i = 0; i < 40; i++) begin
			r = (i < 16) ? {i[1:0], i[3:0]} : 6'($urandom);
			straps = r;
			repeat (8) @(negedge i_mclk);
			check(9'({o_dac, o_ptx}), 9'({1'b0, r[0], 1'b0, r[1]}));
			check(9'(o_stx), 9'({r[3], r[2]}));
			check(9'(o_sec_en), 9'h000);
			check(9'({o_wl, o_fmt}), 9'(fmt_exp({r[4], r[5]})));
		end
		run = 1'b1;
		repeat (200) begin
			@(posedge i_mclk);
			r = {unlock, pcm_n | audio_n, cs_bit, sub_a, 2'h3};
			#1;
			check(9'({cbs_o, dout_o, pin8, pin9, cbs_oe, dout_oe}), 9'(r));
		end
		repeat (200 * FL) @(posedge i_mclk);
		n = 0;
		repeat (192 * FL) begin
			@(posedge i_mclk);
			#1;
			n += int'(pin10 === 1'b1);
		end
		check(9'(n), 9'(FL));
		give_verdict();
	end
endmodule // hw_control_mode_and_startup_tb

// file: dv/hwcms_partner.sv
// Behavioural model of the receiver status sources and frame timing seen by the block
`timescale 1ns/1ps
module hwcms_partner #(
	parameter int FRAME_LEN = 4 // Cycles per frame, kept short for simulation
) (
	input  wire logic i_mclk,
	input  wire logic i_run,
	output logic      o_unlock             = 1'b0,
	output logic      o_pcm_n              = 1'b0,
	output logic      o_audio_n            = 1'b0,
	output logic      o_channel_status_bit = 1'b0,
	output logic      o_subframe_a         = 1'b0,
	output logic      o_frame_start        = 1'b0
);
	int phase = 0; // Position inside the current frame
	// New flags every cycle, frame start at phase zero, sub-frame A in the first half
	always @(negedge i_mclk) begin
		if (i_run) begin
			o_frame_start <= (phase == 0);
			o_subframe_a <= (phase < FRAME_LEN / 2);
			{o_unlock, o_pcm_n, o_audio_n, o_channel_status_bit} <= 4'($urandom);
			phase <= (phase + 1) % FRAME_LEN;
		end else begin
			// Idle receiver shows no frames and no flags
			{o_unlock, o_pcm_n, o_audio_n, o_channel_status_bit} <= 4'h0;
			{o_subframe_a, o_frame_start} <= 2'h0;
		end
	end
endmodule // hwcms_partner

// file: hw/hwcms_sync3.sv
// Three-stage input synchroniser with agreement on the last two stages
`timescale 1ns/1ps
module hwcms_sync3 #(
	parameter int W = 1
) (
	input  wire logic         i_mclk,
	input  wire logic         i_rst_n,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] s1_q;   // First stage, read only by the second
	logic [W-1:0] s2_q;   // Second stage
	logic [W-1:0] s3_q;   // Third stage

	// Shift chain
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= i_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Output moves only when stages two and three agree
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge i_mclk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					o_sync[g] <= 1'b0;
				end else if (s2_q[g] == s3_q[g]) begin
					o_sync[g] <= s3_q[g];
				end
			end
		end
	endgenerate
endmodule // hwcms_sync3

// file: hw/hwcms_top.sv
// Start-up sequencing, register file, identification and hardware-mode pins
`timescale 1ns/1ps
module hwcms_top
	import hwcms_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	input  wire logic        i_internal_reset_n,
	input  wire logic        i_wr_en,
	input  wire logic        i_rd_en,
	input  wire logic [6:0]  i_addr,
	input  wire logic [8:0]  i_wdata,
	input  wire logic        i_continuous_readback,
	input  wire logic        i_control_mode_pin,
	input  wire logic        i_control_bus_select_pin,
	input  wire logic        i_route_pin_a,
	input  wire logic        i_route_pin_b,
	input  wire logic        i_route_pin_c,
	input  wire logic        i_route_pin_d,
	input  wire logic        i_chip_select_pin,
	input  wire logic        i_serial_clock_pin,
	input  wire logic        i_unlock,
	input  wire logic        i_pcm_n,
	input  wire logic        i_audio_n,
	input  wire logic        i_channel_status_bit,
	input  wire logic        i_subframe_a,
	input  wire logic        i_frame_start,
	output logic [8:0]       o_rdata,
	output logic             o_rvalid,
	output logic             o_ready,
	output logic             o_hw_mode,
	output logic             o_three_wire,
	output logic [1:0]       o_dac_source_select,
	output logic [1:0]       o_primary_tx_source_select,
	output logic [1:0]       o_spdif_tx_source_select,
	output logic             o_secondary_audio_port_en,
	output logic [1:0]       o_primary_fmt,
	output logic [1:0]       o_primary_wl,
	output logic             o_midrail_impedance_select,
	output logic             o_control_bus_select_pin_o,
	output logic             o_control_bus_select_pin_oe,
	output logic             o_serial_data_out_pin_o,
	output logic             o_serial_data_out_pin_oe,
	output logic             o_multifunction_pin_eight,
	output logic             o_multifunction_pin_nine,
	output logic             o_multifunction_pin_ten
);
	logic [6:1]   straps;        // Synchronised route and format straps
	logic         hw_mode;       // Synchronised mode pin
	logic         bus_sel;       // Synchronised bus select pin
	logic         ready_int_n;   // Synchronised internal reset
	hwcms_state_t state_q;       // Start-up state
	logic [8:0]   adc_ctl_q;     // Midrail and ADC control register
	logic [8:0]   pri_rx_cfg_q;  // DAC source and receive format
	logic [8:0]   pri_tx_cfg_q;  // Primary transmit source and format
	logic [8:0]   sec_cfg_q;     // S/PDIF transmit source and secondary enable
	logic [7:0]   frame_cnt_q;   // Frame position within the status block
	logic         frame_seen_q;  // A frame start has been seen
	logic         ready;         // Writes accepted

	// Format pin pair to frame format
	function automatic logic [1:0] fmt_of(input logic [1:0] p);
		case (p)
			2'h0:    fmt_of = FMT_RJ;
			2'h1:    fmt_of = FMT_RJ;
			2'h2:    fmt_of = FMT_LJ;
			default: fmt_of = FMT_I2S;
		endcase
	endfunction

	// Format pin pair to word length
	function automatic logic [1:0] wl_of(input logic [1:0] p);
		wl_of = (p == 2'h1) ? WL_20 : WL_24;
	endfunction

	// Strap, mode and reset synchronisers
	hwcms_sync3 #(.W(9)) u_sync (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_async ({i_internal_reset_n, i_control_mode_pin, i_control_bus_select_pin,
			i_route_pin_a, i_route_pin_b, i_route_pin_c, i_route_pin_d,
			i_chip_select_pin, i_serial_clock_pin}),
		.o_sync  ({ready_int_n, hw_mode, bus_sel, straps[6:1]})
	);

	assign ready = (state_q == HWCMS_READY);

	// Start-up sequence: hold, load defaults, then ready
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= HWCMS_HOLD;
		end else if (!ready_int_n) begin
			state_q <= HWCMS_HOLD;
		end else begin
			case (state_q)
				HWCMS_HOLD:  state_q <= HWCMS_LOAD;
				HWCMS_LOAD:  state_q <= HWCMS_READY;
				HWCMS_READY: state_q <= HWCMS_READY;
				default:     state_q <= HWCMS_HOLD;
			endcase
		end
	end

	// Software-writable registers; defaults reloaded while held
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			adc_ctl_q    <= ADC_CONTROL_ONE_RST;
			pri_rx_cfg_q <= PRI_PORT_THREE_RST;
			pri_tx_cfg_q <= PRI_PORT_FOUR_RST;
			sec_cfg_q    <= SEC_PORT_TWO_RST;
		end else if (state_q != HWCMS_READY) begin
			adc_ctl_q    <= ADC_CONTROL_ONE_RST;
			pri_rx_cfg_q <= PRI_PORT_THREE_RST;
			pri_tx_cfg_q <= PRI_PORT_FOUR_RST;
			sec_cfg_q    <= SEC_PORT_TWO_RST;
		end else if (i_wr_en && !hw_mode) begin
			case (i_addr)
				ADDR_ADC_CONTROL_ONE: adc_ctl_q <= i_wdata;
				ADDR_PRI_PORT_THREE:  pri_rx_cfg_q <= i_wdata;
				ADDR_PRI_PORT_FOUR:   pri_tx_cfg_q <= i_wdata;
				ADDR_SEC_PORT_TWO:    sec_cfg_q    <= i_wdata;
				default:              ;
			endcase
		end
	end

	// Read port with identification readback
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata  <= '0;
			o_rvalid <= 1'b0;
		end else begin
			o_rvalid <= i_rd_en && ready;
			if (i_rd_en && ready) begin
				case (i_addr)
					ADDR_IDENT_ONE: o_rdata <= i_continuous_readback ? '0 : IDENT_ONE_VAL;
					ADDR_IDENT_TWO: o_rdata <= i_continuous_readback ? '0 : IDENT_TWO_VAL;
					ADDR_REVISION:  o_rdata <= i_continuous_readback ? '0 : REVISION_VAL;
					ADDR_ADC_CONTROL_ONE: o_rdata <= adc_ctl_q;
					ADDR_PRI_PORT_THREE:  o_rdata <= pri_rx_cfg_q;
					ADDR_PRI_PORT_FOUR:   o_rdata <= pri_tx_cfg_q;
					ADDR_SEC_PORT_TWO:    o_rdata <= sec_cfg_q;
					default:              o_rdata <= '0;
				endcase
			end
		end
	end

	// Channel status block frame counter
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			frame_cnt_q  <= '0;
			frame_seen_q <= 1'b0;
		end else if (i_frame_start) begin
			frame_seen_q <= 1'b1;
			frame_cnt_q  <= (frame_cnt_q == BLOCK_FRAMES - 8'h01) ? 8'h00 : frame_cnt_q + 8'h01;
		end
	end

	// Configuration outputs: straps or fixed defaults in hardware mode, registers otherwise
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_hw_mode                  <= 1'b0;
			o_three_wire               <= 1'b0;
			o_dac_source_select        <= PRI_PORT_THREE_RST[SRC_HI:SRC_LO];
			o_primary_tx_source_select <= PRI_PORT_FOUR_RST[SRC_HI:SRC_LO];
			o_spdif_tx_source_select   <= SEC_PORT_TWO_RST[SRC_HI:SRC_LO];
			o_secondary_audio_port_en  <= 1'b0;
			o_primary_fmt              <= PRI_PORT_FOUR_RST[FMT_HI:FMT_LO];
			o_primary_wl               <= PRI_PORT_FOUR_RST[WL_HI:WL_LO];
			o_midrail_impedance_select <= ADC_CONTROL_ONE_RST[MIDRAIL_BIT];
			o_ready                    <= 1'b0;
		end else begin
			o_ready                    <= ready;
			o_hw_mode                  <= hw_mode;
			o_three_wire               <= !hw_mode && bus_sel;
			// Hardware mode runs at the default whatever software left behind
			o_midrail_impedance_select <= hw_mode ? ADC_CONTROL_ONE_RST[MIDRAIL_BIT]
				: adc_ctl_q[MIDRAIL_BIT];
			if (hw_mode) begin
				o_dac_source_select        <= straps[6] ? DAC_FROM_PRI : DAC_FROM_SPDIF;
				o_primary_tx_source_select <= straps[5] ? PTX_SRC_ADC : PTX_SRC_SPDIF;
				o_spdif_tx_source_select   <= {straps[3], straps[4]};
				o_secondary_audio_port_en  <= 1'b0;
				o_primary_fmt              <= fmt_of(straps[2:1]);
				o_primary_wl               <= wl_of(straps[2:1]);
			end else begin
				o_dac_source_select        <= pri_rx_cfg_q[SRC_HI:SRC_LO];
				o_primary_tx_source_select <= pri_tx_cfg_q[SRC_HI:SRC_LO];
				o_spdif_tx_source_select   <= sec_cfg_q[SRC_HI:SRC_LO];
				o_secondary_audio_port_en  <= sec_cfg_q[SEC_EN_BIT];
				o_primary_fmt              <= pri_tx_cfg_q[FMT_HI:FMT_LO];
				o_primary_wl               <= pri_tx_cfg_q[WL_HI:WL_LO];
			end
		end
	end

	// Status pins carry flags only in hardware mode; bus select and data out enables are off otherwise
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_control_bus_select_pin_o  <= 1'b0;
			o_control_bus_select_pin_oe <= 1'b0;
			o_serial_data_out_pin_o     <= 1'b0;
			o_serial_data_out_pin_oe    <= 1'b0;
			o_multifunction_pin_eight   <= 1'b0;
			o_multifunction_pin_nine    <= 1'b0;
			o_multifunction_pin_ten     <= 1'b0;
		end else begin
			o_control_bus_select_pin_oe <= hw_mode;
			o_control_bus_select_pin_o  <= hw_mode && i_unlock;
			o_serial_data_out_pin_oe    <= hw_mode;
			o_serial_data_out_pin_o     <= hw_mode && (i_pcm_n || i_audio_n);
			o_multifunction_pin_eight   <= hw_mode && i_channel_status_bit;
			o_multifunction_pin_nine    <= hw_mode && i_subframe_a;
			o_multifunction_pin_ten     <= hw_mode && frame_seen_q
				&& (i_frame_start ? (frame_cnt_q == BLOCK_FRAMES - 8'h01)
				: (frame_cnt_q == 8'h00));
		end
	end

	// Writes before ready leave the register at its default
	AST_EARLY_WRITE_DROPPED: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(!ready && i_wr_en) |=> (adc_ctl_q == ADC_CONTROL_ONE_RST))
		else $error("write taken before ready");

	// Midrail bit at default in the cycle after load
	AST_MIDRAIL_DEFAULT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(state_q == HWCMS_LOAD) |=> adc_ctl_q[MIDRAIL_BIT])
		else $error("midrail bit not at default");

	// Ready state follows internal reset release within bounds
	sequence s_released;
		ready_int_n [*3];
	endsequence
	AST_RESET_RELEASE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		s_released |-> ready)
		else $error("ready not reached after release");

	AST_HOLD_IN_RESET: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		!ready_int_n |=> !ready)
		else $error("ready while held");

	AST_ID_READ: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_rd_en && ready && !i_continuous_readback && i_addr == ADDR_IDENT_TWO)
		|=> o_rvalid && o_rdata == IDENT_TWO_VAL)
		else $error("identification byte wrong");

	AST_NO_ID_CONT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_rd_en && ready && i_continuous_readback && i_addr == ADDR_IDENT_ONE)
		|=> o_rdata == '0)
		else $error("identification in continuous readback");

	AST_SEC_PORT_OFF: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		hw_mode |=> !o_secondary_audio_port_en)
		else $error("secondary port on in hardware mode");

	AST_UNLOCK_PIN: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		hw_mode |=> o_control_bus_select_pin_oe && o_control_bus_select_pin_o == $past(i_unlock))
		else $error("unlock pin wrong");

	AST_NONAUDIO_PIN: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		hw_mode |=> o_serial_data_out_pin_o == ($past(i_pcm_n) || $past(i_audio_n)))
		else $error("non-audio pin wrong");

	AST_DAC_ROUTE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(hw_mode && straps[6]) |=> o_dac_source_select == DAC_FROM_PRI)
		else $error("DAC route wrong");

	// Mode flag follows the synchronised mode pin
	AST_MODE_PIN: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		1'b1 |=> o_hw_mode == $past(hw_mode))
		else $error("mode flag wrong");

	// Bus protocol follows the select pin only in software mode
	AST_THREE_WIRE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		1'b1 |=> o_three_wire == (!$past(hw_mode) && $past(bus_sel)))
		else $error("bus protocol select wrong");

	// Midrail register bit never leaks into hardware mode
	AST_HW_DEFAULTS: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		hw_mode |=> o_midrail_impedance_select == ADC_CONTROL_ONE_RST[MIDRAIL_BIT])
		else $error("register setting used in hardware mode");

	// Pin d is the high bit of the transmit source, pin c the low bit
	AST_SPDIF_ROUTE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(hw_mode && straps[3] && !straps[4]) |=> o_spdif_tx_source_select == 2'h2)
		else $error("transmit route wrong");

	// Chip select high with serial clock low gives 24-bit left justified
	AST_FORMAT_PINS: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(hw_mode && straps[2] && !straps[1])
		|=> o_primary_fmt == FMT_LJ && o_primary_wl == WL_24)
		else $error("primary format wrong");

	// Channel status and sub-frame pins copy the receiver flags
	AST_FRAME_PINS: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		hw_mode |=> o_multifunction_pin_eight == $past(i_channel_status_bit)
			&& o_multifunction_pin_nine == $past(i_subframe_a))
		else $error("frame pins wrong");

	// Last frame of a block ends, so frame zero is flagged next
	sequence s_last_frame_ends;
		hw_mode && frame_seen_q && i_frame_start && (frame_cnt_q == BLOCK_FRAMES - 8'h01);
	endsequence
	AST_BLOCK_PIN_HIGH: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		s_last_frame_ends |=> o_multifunction_pin_ten)
		else $error("block start pin missing");

	// Any other frame start leaves the block pin low
	AST_BLOCK_PIN_LOW: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_frame_start && frame_cnt_q != BLOCK_FRAMES - 8'h01) |=> !o_multifunction_pin_ten)
		else $error("block start pin high outside frame zero");
endmodule // hwcms_top
